// ### design/usbl_link_ctrl.sv
// Control logic of a full/low-speed USB device link behind a Wishbone slave.
// How it works
// (R1) Reset: clock frozen, registers default, detached.
// (R2) Pull-up on only when attached and VBUS present.
// (R3) Clearing controller enable resets the controller.
// (R4) Bus reset end sets flag, speed valid.
// (R5) Endpoint reset bit clears endpoint state, keeps toggle.
// (R6) Bus reset disables endpoints, resets control endpoint.
// (R7) Firmware selects endpoint before endpoint access.
// (R8) Disabled endpoint is held in reset.
// (R9) Firmware activates endpoint in documented order.
// (R10) No acknowledge while configuration is invalid.
// (R11) Disable resets endpoint and toggle, keeps configuration.
// (R12) Firmware enables address after zero-length status.
// (R13) Firmware never writes address and enable together.
// (R14) Respond to stored address only when enabled.
// (R15) Address field returns to zero on reset.
// (R16) Address enable cleared by resets and disable.
// (R17) 3 ms idle: full speed, suspend flag.
// (R18) Non-idle line sets wake-up flag anytime.
// (R19) Wake-up and suspend flags clear each other.
// (R20) Detach resets to one and gates pull-up.
// (R21) Remote wake-up after suspend, after 5 ms idle.
// (R22) Resume start sets flag; end clears request.
// (R23) Host end of resume sets its flag.
// (R24) Clock freeze gates clocks, resume detect stays.
// (R25) Disable also stops transceiver and clocks.
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module usbl_link_ctrl #(
  parameter int unsigned SUSP_CYC = usbl_pkg::SUSPEND_US * usbl_pkg::CLK_MHZ,
  parameter int unsigned RMWK_CYC = usbl_pkg::RMWK_IDLE_US * usbl_pkg::CLK_MHZ,
  parameter int unsigned DRV_CYC  = usbl_pkg::RESUME_DRIVE_US * usbl_pkg::CLK_MHZ
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire usbl_pkg::usbl_line_t line_i,
  input  wire logic [6:0]           ep_event_i,
  input  wire logic [6:0]           ep_toggle_i,
  output logic                      pullup_en_o,
  output logic                      xcvr_en_o,
  output logic                      clk_run_o,
  output logic                      resume_drive_o,
  output logic      [6:0]           dev_addr_o,
  output logic      [6:0]           ep_ack_en_o,
  output logic      [6:0]           ep_toggle_o
);
  localparam int unsigned NEP = usbl_pkg::NUM_EP;
  // Last cycle numbers of each timed interval; counts start at zero.
  localparam logic [23:0] SUSP_LAST = 24'(SUSP_CYC - 1);
  localparam logic [23:0] RMWK_LAST = 24'(RMWK_CYC - 1);
  localparam logic [23:0] DRV_LAST  = 24'(DRV_CYC - 1);

  logic             ack_q;        // Bus acknowledge, one cycle.
  logic [31:0]      rdat_q;       // Registered read data.
  logic [1:0]       ctrl_q;       // Enable (bit 1) and clock freeze (bit 0).
  logic             detach_q;     // Pull-up disconnect control.
  logic             rmw_q;        // Remote wake-up request.
  logic [6:0]       addr_q;       // Stored device address.
  logic             addr_en_q;    // Address enable.
  logic [7:0]       flags_q;      // Sticky event flags.
  logic             speed_q;      // Speed status, one is full speed.
  logic             brst_q;       // Bus reset level, one cycle old.
  logic             idle_q;       // Idle level, one cycle old.
  logic             had_susp_q;   // A suspend has been seen.
  logic [23:0]      idle_cnt_q;   // Continuous idle cycles.
  logic [23:0]      drv_cnt_q;    // Resume drive cycles.
  usbl_pkg::usbl_rw_t rw_q;       // Remote wake-up sequencer.
  logic [2:0]       endpoint_number_q;      // Selected endpoint number.
  logic             ovr_q;        // Endpoint select override.
  logic [6:0]       eprst_q;      // Endpoint reset bits.
  logic [6:0]       en_q;         // Endpoint enables.
  logic [6:0]       dir_q;        // Endpoint directions.
  logic [1:0]       type_q [NEP]; // Endpoint types.
  logic [2:0]       size_q [NEP]; // Endpoint size codes.
  logic [6:0]       bank_q;       // Two banks when set.
  logic [6:0]       memory_allocate_q;      // Memory allocated.
  logic [6:0]       evt_q;        // Endpoint interrupt bit.
  logic [6:0]       cfg_ok;       // Configuration valid per endpoint.
  logic [6:0]       hold;         // Endpoint held in reset.
  logic [7:0]       rd_d;         // Read mux result.

  // Decode of the bus request; a slave answers each request exactly once.
  logic       req, wr, rd, ctl_rst, run, brst_now, brst_end;
  logic       susp_set, wake_set, up_set, rw_end, ep_ok;
  logic [7:0] wd;
  assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr       = req & wb_we_i & wb_sel_i[0];
  assign rd       = req & ~wb_we_i;
  assign wd       = wb_dat_i[7:0];
  assign ctl_rst  = rst_i | ~ctrl_q[1];                        // [R3]
  assign run      = ctrl_q[1] & ~ctrl_q[0];                    // [R24]
  assign brst_now = line_i.bus_reset;
  assign brst_end = brst_q & ~line_i.bus_reset;
  assign wake_set = ctrl_q[1] & idle_q & ~line_i.idle;         // [R18]
  assign susp_set = run & line_i.idle & (idle_cnt_q == SUSP_LAST); // [R17]
  assign up_set   = (rw_q == usbl_pkg::RW_WAIT) & run & line_i.idle
                    & (idle_cnt_q >= RMWK_LAST);               // [R21]
  assign rw_end   = (rw_q == usbl_pkg::RW_DRIVE) & (drv_cnt_q == DRV_LAST);
  assign ep_ok    = ~ovr_q & (32'(endpoint_number_q) < NEP);

  // Bytes an endpoint needs: size code scaled, doubled for two banks.
  function automatic logic [15:0] ep_bytes(input logic [2:0] code, input logic two);
    ep_bytes = (usbl_pkg::EP_MIN_BYTES << code) << two;
  endfunction : ep_bytes

  // Wishbone answer: ack one cycle after the request, then drop.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req;
      if (rd) begin
        rdat_q <= {24'h00_0000, rd_d};
      end
    end
  end

  // Enable and freeze live outside the controller reset, else enable could not be set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= usbl_pkg::CTRL_RST;                            // [R1]
    end else if (wr && wb_adr_i == usbl_pkg::ADR_CTRL) begin
      ctrl_q <= {wd[usbl_pkg::CTRL_EN], wd[usbl_pkg::CTRL_FRZ]};
    end
  end

  // Detach and remote wake-up request.
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      detach_q <= usbl_pkg::DETACH_RST;                        // [R1] [R20]
      rmw_q    <= 1'b0;
    end else if (rw_end) begin
      rmw_q    <= 1'b0;                                        // [R22]
    end else if (wr && wb_adr_i == usbl_pkg::ADR_DEV) begin
      detach_q <= wd[usbl_pkg::DEV_DET];                       // [R20]
      // A request without a prior suspend is ignored.
      if (wd[usbl_pkg::DEV_RMW] && had_susp_q) begin
        rmw_q <= 1'b1;                                         // [R21]
      end
    end
  end

  // Device address; firmware must write field and enable in separate writes.
  always_ff @(posedge clk_i) begin
    if (ctl_rst || brst_now) begin
      addr_q    <= usbl_pkg::ADDR_DEFAULT;                     // [R15]
      addr_en_q <= 1'b0;                                       // [R16]
    end else if (wr && wb_adr_i == usbl_pkg::ADR_ADDR) begin
      addr_q    <= wd[6:0];                                    // [R12] [R13]
      addr_en_q <= wd[usbl_pkg::ADDR_EN];
    end
  end

  // Line history for edge detection and the idle counter.
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      brst_q     <= 1'b0;
      idle_q     <= 1'b1;
      idle_cnt_q <= 24'h00_0000;
    end else begin
      brst_q <= line_i.bus_reset;
      idle_q <= line_i.idle;
      // The count is held at zero while frozen; the line history and wake-up detection keep running.
      if (!run || !line_i.idle) begin
        idle_cnt_q <= 24'h00_0000;
      end else if (idle_cnt_q != 24'hFF_FFFF) begin
        idle_cnt_q <= idle_cnt_q + 24'h00_0001;
      end
    end
  end

  // Speed status: taken at bus reset end, forced full on suspend.
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      speed_q <= 1'b0;
    end else if (susp_set) begin
      speed_q <= 1'b1;                                         // [R17]
    end else if (brst_end) begin
      speed_q <= line_i.full_speed;                            // [R4]
    end
  end

  // Sticky flags: write one to clear, a hardware set wins over the clear.
  always_ff @(posedge clk_i) begin
    logic [7:0] clr;
    clr = (wr && wb_adr_i == usbl_pkg::ADR_FLAGS) ? wd : 8'h00;
    if (ctl_rst) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= flags_q & ~clr;
      flags_q[usbl_pkg::FLG_SUSP] <= susp_set | (flags_q[usbl_pkg::FLG_SUSP]
        & ~clr[usbl_pkg::FLG_SUSP] & ~wake_set & ~up_set);     // [R19] [R22]
      flags_q[usbl_pkg::FLG_WAKE] <= wake_set | (flags_q[usbl_pkg::FLG_WAKE]
        & ~clr[usbl_pkg::FLG_WAKE] & ~susp_set);               // [R18] [R19]
      flags_q[usbl_pkg::FLG_EORST] <= brst_end |
        (flags_q[usbl_pkg::FLG_EORST] & ~clr[usbl_pkg::FLG_EORST]); // [R4]
      flags_q[usbl_pkg::FLG_EORES] <= line_i.host_eor |
        (flags_q[usbl_pkg::FLG_EORES] & ~clr[usbl_pkg::FLG_EORES]); // [R23]
      flags_q[usbl_pkg::FLG_UPRES] <= up_set |
        (flags_q[usbl_pkg::FLG_UPRES] & ~clr[usbl_pkg::FLG_UPRES]); // [R22]
    end
  end

  // Remembers a suspend so that remote wake-up becomes legal.
  always_ff @(posedge clk_i) begin
    if (ctl_rst || brst_now) begin
      had_susp_q <= 1'b0;
    end else if (susp_set) begin
      had_susp_q <= 1'b1;                                      // [R21]
    end
  end

  // Remote wake-up sequencer: wait for idle, then drive resume.
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      rw_q      <= usbl_pkg::RW_IDLE;
      drv_cnt_q <= 24'h00_0000;
    end else begin
      unique case (rw_q)
        usbl_pkg::RW_IDLE: begin
          drv_cnt_q <= 24'h00_0000;
          if (rmw_q) begin
            rw_q <= usbl_pkg::RW_WAIT;
          end
        end
        usbl_pkg::RW_WAIT: begin
          if (up_set) begin
            rw_q <= usbl_pkg::RW_DRIVE;                        // [R21]
          end
        end
        usbl_pkg::RW_DRIVE: begin
          drv_cnt_q <= drv_cnt_q + 24'h00_0001;
          if (rw_end) begin
            rw_q <= usbl_pkg::RW_IDLE;                         // [R22]
          end
        end
        default: begin
          rw_q <= usbl_pkg::RW_IDLE;
        end
      endcase
    end
  end

  // Endpoint selection and endpoint reset bits; software clears the reset bits.
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      endpoint_number_q <= 3'h0;
      ovr_q   <= 1'b0;
      eprst_q <= 7'h00;
    end else begin
      if (wr && wb_adr_i == usbl_pkg::ADR_EPSEL) begin
        endpoint_number_q <= wd[2:0];                                    // [R7]
        ovr_q   <= wd[usbl_pkg::SEL_OVR];
      end
      if (wr && wb_adr_i == usbl_pkg::ADR_EPRST) begin
        eprst_q <= wd[6:0];                                    // [R5]
      end
    end
  end

  // Per-endpoint state; only the selected endpoint takes writes.
  for (genvar i = 0; i < NEP; i++) begin : g_ep
    logic sel, wa, wb;
    assign sel = ep_ok & (endpoint_number_q == 3'(i));
    assign wa  = wr & sel & (wb_adr_i == usbl_pkg::ADR_EPCFA);
    assign wb  = wr & sel & (wb_adr_i == usbl_pkg::ADR_EPCFB);
    assign hold[i] = ~en_q[i] | eprst_q[i] | ((i == 0) & brst_now); // [R5] [R8]
    assign cfg_ok[i] = en_q[i] & memory_allocate_q[i] &
      (ep_bytes(size_q[i], bank_q[i]) <= usbl_pkg::EP_MEM_BYTES); // [R10]

    // Enable: bus reset keeps only the control endpoint.
    always_ff @(posedge clk_i) begin
      if (ctl_rst || (brst_now && i != 0)) begin
        en_q[i] <= 1'b0;                                       // [R6]
      end else if (wa) begin
        en_q[i] <= wd[usbl_pkg::CFA_ENA];                      // [R9]
      end
    end

    // Configuration survives disable and endpoint reset.
    always_ff @(posedge clk_i) begin
      if (ctl_rst) begin
        dir_q[i]   <= 1'b0;
        type_q[i]  <= 2'h0;
        size_q[i]  <= 3'h0;
        bank_q[i]  <= 1'b0;
        memory_allocate_q[i] <= 1'b0;
      end else if (wa) begin
        dir_q[i]  <= wd[usbl_pkg::CFA_DIR];
        type_q[i] <= wd[usbl_pkg::CFA_TYP +: 2];
      end else if (wb) begin
        size_q[i]  <= wd[usbl_pkg::CFB_SIZ +: 3];              // [R11]
        bank_q[i]  <= wd[usbl_pkg::CFB_BNK];
        memory_allocate_q[i] <= wd[usbl_pkg::CFB_ALC];
      end
    end

    // Data toggle: kept by endpoint reset, cleared by disable or command.
    always_ff @(posedge clk_i) begin
      if (ctl_rst || !en_q[i] || (brst_now && i == 0) ||
          (wa && wd[usbl_pkg::CFA_TCLR])) begin
        ep_toggle_o[i] <= 1'b0;                                // [R6] [R11]
      end else if (ep_toggle_i[i]) begin
        ep_toggle_o[i] <= ~ep_toggle_o[i];
      end
    end

    // Endpoint interrupt bit: held clear in reset, set wins over clear.
    always_ff @(posedge clk_i) begin
      if (ctl_rst || hold[i]) begin
        evt_q[i] <= 1'b0;                                      // [R5] [R8]
      end else begin
        evt_q[i] <= ep_event_i[i] | (evt_q[i] &
          ~(wr && sel && wb_adr_i == usbl_pkg::ADR_EPINT && wd[0]));
      end
    end
  end

  // Read mux; endpoint registers read zero with no valid selection.
  always_comb begin
    logic [2:0] n;
    n    = ep_ok ? endpoint_number_q : 3'h0;
    rd_d = 8'h00;
    unique case (wb_adr_i)
      usbl_pkg::ADR_CTRL: begin
        rd_d[usbl_pkg::CTRL_EN]  = ctrl_q[1];
        rd_d[usbl_pkg::CTRL_FRZ] = ctrl_q[0];
      end
      usbl_pkg::ADR_DEV: begin
        rd_d[usbl_pkg::DEV_DET] = detach_q;
        rd_d[usbl_pkg::DEV_RMW] = rmw_q;
      end
      usbl_pkg::ADR_ADDR:  rd_d = {addr_en_q, addr_q};
      usbl_pkg::ADR_FLAGS: rd_d = flags_q;
      usbl_pkg::ADR_STAT: begin
        rd_d[usbl_pkg::STA_SPD]  = speed_q;
        rd_d[usbl_pkg::STA_VBUS] = line_i.vbus;
        rd_d[usbl_pkg::STA_CFOK] = ep_ok & cfg_ok[n];
        rd_d[usbl_pkg::STA_TOG]  = ep_ok & ep_toggle_o[n];
      end
      usbl_pkg::ADR_EPSEL: rd_d = {4'h0, ovr_q, endpoint_number_q};
      usbl_pkg::ADR_EPRST: rd_d = {1'b0, eprst_q};
      usbl_pkg::ADR_EPCFA: if (ep_ok) begin
        rd_d[usbl_pkg::CFA_ENA]      = en_q[n];
        rd_d[usbl_pkg::CFA_DIR]      = dir_q[n];
        rd_d[usbl_pkg::CFA_TYP +: 2] = type_q[n];
      end
      usbl_pkg::ADR_EPCFB: if (ep_ok) begin
        rd_d[usbl_pkg::CFB_SIZ +: 3] = size_q[n];
        rd_d[usbl_pkg::CFB_BNK]      = bank_q[n];
        rd_d[usbl_pkg::CFB_ALC]      = memory_allocate_q[n];
      end
      usbl_pkg::ADR_EPINT: rd_d[0] = ep_ok & evt_q[n];
      default: rd_d = 8'h00;
    endcase
  end

  // Registered pin controls; each lags its cause by one cycle.
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      pullup_en_o    <= 1'b0;                                  // [R1]
      xcvr_en_o      <= 1'b0;                                  // [R25]
      clk_run_o      <= 1'b0;                                  // [R25]
      resume_drive_o <= 1'b0;
      dev_addr_o     <= usbl_pkg::ADDR_DEFAULT;
      ep_ack_en_o    <= 7'h00;
    end else begin
      pullup_en_o    <= ~detach_q & line_i.vbus;               // [R2] [R20]
      xcvr_en_o      <= 1'b1;
      clk_run_o      <= run;                                   // [R24]
      resume_drive_o <= (rw_q == usbl_pkg::RW_DRIVE) & ~rw_end;
      dev_addr_o     <= addr_en_q ? addr_q : usbl_pkg::ADDR_DEFAULT; // [R14]
      ep_ack_en_o    <= cfg_ok & ~hold;                        // [R10]
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  chk_reset_state: assert property (@(posedge clk_i) $fell(rst_i) |->  // [R1]
    !clk_run_o && !pullup_en_o && detach_q) else $error("bad reset state");
  chk_pullup_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    pullup_en_o |-> $past(!detach_q && line_i.vbus && ctrl_q[1]))
    else $error("pull-up without attach");
  chk_disable_all: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    !ctrl_q[1] |=> !xcvr_en_o && ep_ack_en_o == 7'h00 && !addr_en_q)
    else $error("disable did not reset");
  chk_eorst_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    ctrl_q[1] && brst_end |=> flags_q[usbl_pkg::FLG_EORST])
    else $error("end of bus reset missed");
  chk_eprst_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    eprst_q[1] |=> !ep_ack_en_o[1] && !evt_q[1]) else $error("endpoint reset failed");
  chk_busrst_eps: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    ctrl_q[1] && brst_now |=> en_q[6:1] == 6'h00 && !ep_toggle_o[0])
    else $error("bus reset left endpoints");
  chk_disabled_ep: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    !en_q[2] |=> !ep_toggle_o[2] && !ep_ack_en_o[2]) else $error("disabled endpoint live");
  chk_cfg_ack: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    ep_ack_en_o[0] |-> $past(cfg_ok[0])) else $error("ack without valid config");
  chk_addr_default: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    ctrl_q[1] && !addr_en_q |=> dev_addr_o == usbl_pkg::ADDR_DEFAULT)
    else $error("stored address used while disabled");
  chk_susp_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    susp_set |=> flags_q[usbl_pkg::FLG_SUSP] && !flags_q[usbl_pkg::FLG_WAKE] && speed_q)
    else $error("suspend flag wrong");
  chk_wake_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    wake_set && !susp_set |=> flags_q[usbl_pkg::FLG_WAKE] && !flags_q[usbl_pkg::FLG_SUSP])
    else $error("wake-up flag wrong");
  chk_resume_seq: assert property (@(posedge clk_i) disable iff (rst_i) // [R22]
    up_set |=> flags_q[usbl_pkg::FLG_UPRES] && !flags_q[usbl_pkg::FLG_SUSP]
    ##1 resume_drive_o) else $error("upstream resume start wrong");
  chk_rmw_end: assert property (@(posedge clk_i) disable iff (rst_i) // [R22]
    rw_end |=> !rmw_q && rw_q == usbl_pkg::RW_IDLE) else $error("request not cleared");
endmodule : usbl_link_ctrl

// ### design/usbl_pkg.sv
// Shared constants, register map and types for the USB device link control block.
package usbl_pkg;
  // System clock rate in MHz.
  localparam int unsigned CLK_MHZ         = 40;
  // Bus inactivity before suspend, in microseconds.
  localparam int unsigned SUSPEND_US      = 3000;
  // Bus inactivity before upstream resume starts, in microseconds.
  localparam int unsigned RMWK_IDLE_US    = 5000;
  // Length of the upstream resume drive, in microseconds.
  localparam int unsigned RESUME_DRIVE_US = 2000;

  // Endpoint count and index width.
  localparam int unsigned NUM_EP = 7;
  localparam int unsigned EPW    = 3;
  // Endpoint memory and the smallest endpoint size, in bytes.
  localparam logic [15:0] EP_MEM_BYTES = 16'h0200;
  localparam logic [15:0] EP_MIN_BYTES = 16'h0008;

  // Register byte addresses.
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_DEV   = 8'h04;
  localparam logic [7:0] ADR_ADDR  = 8'h08;
  localparam logic [7:0] ADR_FLAGS = 8'h0C;
  localparam logic [7:0] ADR_STAT  = 8'h14;
  localparam logic [7:0] ADR_EPSEL = 8'h18;
  localparam logic [7:0] ADR_EPRST = 8'h1C;
  localparam logic [7:0] ADR_EPCFA = 8'h20;
  localparam logic [7:0] ADR_EPCFB = 8'h24;
  localparam logic [7:0] ADR_EPINT = 8'h2C;

  // Field positions.
  localparam int unsigned CTRL_EN  = 7;
  localparam int unsigned CTRL_FRZ = 5;
  localparam int unsigned DEV_DET  = 0;
  localparam int unsigned DEV_RMW  = 1;
  localparam int unsigned ADDR_EN  = 7;
  localparam int unsigned FLG_SUSP = 0;
  localparam int unsigned FLG_EORST = 2;
  localparam int unsigned FLG_WAKE = 3;
  localparam int unsigned FLG_EORES = 4;
  localparam int unsigned FLG_UPRES = 5;
  localparam int unsigned STA_SPD  = 0;
  localparam int unsigned STA_VBUS = 1;
  localparam int unsigned STA_CFOK = 3;
  localparam int unsigned STA_TOG  = 4;
  localparam int unsigned SEL_OVR  = 3;
  localparam int unsigned CFA_ENA  = 0;
  localparam int unsigned CFA_TCLR = 1;
  localparam int unsigned CFA_DIR  = 2;
  localparam int unsigned CFA_TYP  = 4;
  localparam int unsigned CFB_ALC  = 1;
  localparam int unsigned CFB_BNK  = 2;
  localparam int unsigned CFB_SIZ  = 4;

  // Reset values.
  localparam logic [1:0] CTRL_RST     = 2'h1;
  localparam logic       DETACH_RST   = 1'h1;
  localparam logic [6:0] ADDR_DEFAULT = 7'h00;

  // Line state reported by the transceiver and packet engine.
  typedef struct packed {
    logic vbus;
    logic idle;
    logic bus_reset;
    logic full_speed;
    logic host_eor;
  } usbl_line_t;

  // Remote wake-up sequencer states.
  typedef enum logic [1:0] {
    RW_IDLE  = 2'b00,
    RW_WAIT  = 2'b01,
    RW_DRIVE = 2'b10
  } usbl_rw_t;
endpackage : usbl_pkg

// ### test/tb_top.sv
// Self-checking bench for the USB device link control block.
`timescale 1ns/10ps
module tb_top;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 cyc   = 1'b0;
  logic                 we    = 1'b0;
  logic [7:0]           adr   = 8'h00;
  logic [31:0]          wdat  = 32'h0;
  logic [3:0]           bsel  = 4'hF;
  logic [6:0]           tgl   = 7'h00;
  logic [6:0]           evt   = 7'h00;
  logic [31:0]          rdat, rd;
  logic                 ack, pu, xe, cr, rsd;
  logic [6:0]           da, ackn, tog;
  usbl_pkg::usbl_line_t line;
  int                   err_total = 0;
  int                   checks = 0;
  always #12.5 clk_i = ~clk_i;
  usbl_host_model i_host (.clk_i(clk_i), .line_o(line));
  // Short counts keep suspend and remote wake-up inside a brief run.
  usbl_link_ctrl #(.SUSP_CYC(20), .RMWK_CYC(30), .DRV_CYC(5)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .line_i(line), .ep_event_i(evt), .ep_toggle_i(tgl), .pullup_en_o(pu),
    .xcvr_en_o(xe), .clk_run_o(cr), .resume_drive_o(rsd), .dev_addr_o(da),
    .ep_ack_en_o(ackn), .ep_toggle_o(tog));
  // One classic cycle; the request stands until ack is sampled high.
  // Only the watchdog ends a wait for ack; the master accepts any ack latency.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
  endtask : bus
  // Count a comparison and report a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Read a register and compare it.
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask : rdc
  // Registered outputs trail their cause, so give them time to land.
  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask : settle
  // One-cycle toggle and event pulses from the packet engine, then settle.
  task automatic pulse(input logic [6:0] t, input logic [6:0] e);
    @(posedge clk_i) tgl <= t;
    evt <= e;
    @(posedge clk_i) tgl <= 7'h00;
    evt <= 7'h00;
    settle();
  endtask : pulse
  // Print the verdict and end the run.
  task automatic final_report();
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    final_report();
  end
  initial begin
    int n;
    n = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h00, 32'h20);
    rdc(8'h04, 32'h01);
    chk({pu, xe}, 2'b00);
    bus(1'b1, 8'h00, 8'h80);
    bus(1'b1, 8'h04, 8'h00);
    settle();
    chk({pu, xe, cr}, 3'b111);
    // A write with the low byte lane off must leave detach alone.
    bsel <= 4'hE;
    bus(1'b1, 8'h04, 8'h01);
    bsel <= 4'hF;
    rdc(8'h04, 32'h00);
    bus(1'b1, 8'h04, 8'h01);
    settle();
    chk(pu, 1'b0);
    bus(1'b1, 8'h04, 8'h00);
    bus(1'b1, 8'h08, 8'h05);
    settle();
    chk(da, 7'h00);
    bus(1'b1, 8'h08, 8'h85);
    settle();
    chk(da, 7'h05);
    bus(1'b1, 8'h18, 8'h01);
    bus(1'b1, 8'h20, 8'h01);
    bus(1'b1, 8'h24, 8'h72);
    settle();
    chk(ackn[1], 1'b0);
    bus(1'b1, 8'h24, 8'h02);
    settle();
    chk(ackn[1], 1'b1);
    bus(1'b1, 8'h18, 8'h00);
    bus(1'b1, 8'h20, 8'h01);
    bus(1'b1, 8'h24, 8'h02);
    pulse(7'h03, 7'h03);
    chk({tog[1:0], ackn[1:0]}, 4'hF);
    rdc(8'h2C, 32'h01);
    bus(1'b1, 8'h1C, 8'h03);
    settle();
    chk({tog[1:0], ackn[1:0]}, 4'hC);
    rdc(8'h2C, 32'h00);
    bus(1'b1, 8'h1C, 8'h00);
    // Low speed here, so the suspend check below sees the switch to full speed.
    i_host.bus_reset(8, 1'b0);
    settle();
    // The line carried traffic at enable, so the wake-up flag is up as well.
    rdc(8'h0C, 32'h0C);
    rdc(8'h14, 32'h0A);
    rdc(8'h08, 32'h00);
    chk({da, ackn[1]}, 8'h00);
    chk({tog[1:0], ackn[0]}, 3'b001);
    pulse(7'h01, 7'h00);
    chk(tog[0], 1'b1);
    bus(1'b1, 8'h20, 8'h00);
    settle();
    chk({tog[0], ackn[0]}, 2'b00);
    rdc(8'h24, 32'h02);
    bus(1'b1, 8'h0C, 8'hFF);
    i_host.set_idle(1'b1);
    repeat (25) @(posedge clk_i);
    rdc(8'h0C, 32'h01);
    rdc(8'h14, 32'h03);
    i_host.set_idle(1'b0);
    settle();
    rdc(8'h0C, 32'h08);
    i_host.set_idle(1'b1);
    repeat (25) @(posedge clk_i);
    rdc(8'h0C, 32'h01);
    bus(1'b1, 8'h04, 8'h02);
    while (rsd !== 1'b1 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    chk(rsd, 1'b1);
    rdc(8'h0C, 32'h20);
    repeat (10) @(posedge clk_i);
    rdc(8'h04, 32'h00);
    i_host.set_idle(1'b0);
    i_host.end_resume();
    settle();
    bus(1'b0, 8'h0C, 8'h00);
    chk(rd[4], 1'b1);
    // Frozen: the suspend count stops, yet a line edge still wakes.
    bus(1'b1, 8'h00, 8'hA0);
    bus(1'b1, 8'h0C, 8'hFF);
    i_host.set_idle(1'b1);
    i_host.set_idle(1'b0);
    settle();
    chk(cr, 1'b0);
    rdc(8'h0C, 32'h08);
    bus(1'b1, 8'h08, 8'h83);
    bus(1'b1, 8'h00, 8'h00);
    settle();
    chk({xe, cr}, 2'b00);
    rdc(8'h08, 32'h00);
    final_report();
  end
endmodule : tb_top

// ### test/usbl_host_model.sv
// Behavioural upstream host that drives the line state seen by the device.
`timescale 1ns/10ps
module usbl_host_model (
  input  wire logic           clk_i,
  output usbl_pkg::usbl_line_t line_o
);
  // Power is present and the line carries traffic, so nothing is idle at start.
  initial line_o = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  // Hold a bus reset for n cycles at the given speed, then release it.
  task automatic bus_reset(input int n, input logic fs);
    @(posedge clk_i) line_o.bus_reset <= 1'b1;
    line_o.full_speed <= fs;
    repeat (n) @(posedge clk_i);
    line_o.bus_reset <= 1'b0;
  endtask : bus_reset
  // Let the line go idle or carry traffic again.
  task automatic set_idle(input logic v);
    @(posedge clk_i) line_o.idle <= v;
  endtask : set_idle
  // Send one end of resume; it lasts a single cycle.
  task automatic end_resume();
    @(posedge clk_i) line_o.host_eor <= 1'b1;
    @(posedge clk_i) line_o.host_eor <= 1'b0;
  endtask : end_resume
endmodule : usbl_host_model
